/* core_ctrl_pkg.sv */
package core_ctrl_pkg;

	// register map: printed offset 0x9 is not a multiple of four, so it is an index
	localparam logic [7:0]  CTRL_INDEX       = 8'h09;
	localparam logic [9:0]  CTRL_BYTE_ADDR   = 10'(CTRL_INDEX) << 2;
	localparam logic [9:0]  STATUS_BYTE_ADDR = 10'h030;
	localparam logic [7:0]  CTRL_RESET       = 8'h04;

	// control field positions
	localparam int CLR_HIST_BIT  = 7;
	localparam int BANK_MSB      = 6;
	localparam int BANK_LSB      = 5;
	localparam int RATE_MSB      = 2;
	localparam int RATE_LSB      = 1;
	localparam int RUN_BIT       = 0;
	localparam logic [7:0] CTRL_WMASK = 8'hE7;

	localparam logic [1:0] BANK_A    = 2'h0;
	localparam logic [1:0] BANK_B    = 2'h1;
	localparam logic [1:0] RATE_96K  = 2'h1;
	localparam logic [1:0] RATE_192K = 2'h2;

	// ahb encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	// settings handed to the core sequencer
	typedef struct packed {
		logic       run;
		logic [1:0] rate;
		logic       bank_b;
		logic       clr_hist;
	} core_cfg_s;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RUN,
		SEQ_CLEAR
	} seq_state_e;

endpackage

/* core_sequencer.sv */
`timescale 1ns/10ps
// holds the settings the core actually uses; run and bank change only at a program start, rate only while stopped
module core_sequencer #(
	parameter int CLEAR_CYCLES = 4
) (
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	input  wire core_ctrl_pkg::core_cfg_s req,
	input  wire logic                   prog_start,
	output logic                        running_r,
	output logic [1:0]                  rate_r,
	output logic                        bank_b_r,
	output logic                        clear_r
);
	localparam int CW = $clog2(CLEAR_CYCLES + 1);
	core_ctrl_pkg::seq_state_e state_r;
	core_ctrl_pkg::seq_state_e state_nxt;
	logic [CW-1:0] clr_cnt_r;
	wire bank_change = prog_start && (req.bank_b != bank_b_r);
	wire clr_done    = (clr_cnt_r == CW'(CLEAR_CYCLES - 1));

	// next state: run and bank changes wait for the program boundary
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			core_ctrl_pkg::SEQ_IDLE:
				if (prog_start && req.run)
					state_nxt = core_ctrl_pkg::SEQ_RUN;
			core_ctrl_pkg::SEQ_RUN:
				if (prog_start && !req.run)
					state_nxt = core_ctrl_pkg::SEQ_IDLE;
				else if (bank_change && req.clr_hist)
					state_nxt = core_ctrl_pkg::SEQ_CLEAR;
			core_ctrl_pkg::SEQ_CLEAR:
				if (clr_done)
					state_nxt = core_ctrl_pkg::SEQ_RUN;
			default:
				state_nxt = core_ctrl_pkg::SEQ_IDLE;
		endcase
	end

	// state and applied settings
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_r   <= core_ctrl_pkg::SEQ_IDLE;
			running_r <= 1'b0;
			rate_r    <= core_ctrl_pkg::CTRL_RESET[core_ctrl_pkg::RATE_MSB:core_ctrl_pkg::RATE_LSB];
			bank_b_r  <= 1'b0;
			clear_r   <= 1'b0;
			clr_cnt_r <= '0;
		end else begin
			state_r   <= state_nxt;
			if (prog_start)
				running_r <= req.run;
			if (!req.run && !running_r)
				rate_r <= req.rate;
			if (prog_start)
				bank_b_r <= req.bank_b;
			clear_r   <= (state_nxt == core_ctrl_pkg::SEQ_CLEAR);
			clr_cnt_r <= (state_r == core_ctrl_pkg::SEQ_CLEAR) ? clr_cnt_r + CW'(1) : '0;
		end
	end
endmodule // core_sequencer

/* core_run_bank_control.sv */
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
// Contract
// - bit 7 set: bank switch while running zeroes filter history
// - bits 6:5 pick bank A or B
// - bits 2:1 pick 96k or 192k rate
// - rate change applies only while stopped
// - bit 0 starts/stops core at program start
module core_run_bank_control #(
	parameter int CLEAR_CYCLES = 4
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [9:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        prog_start,
	output logic             core_running,
	output logic [1:0]       core_rate,
	output logic             core_bank_b,
	output logic             core_clear
);
	// control register as software wrote it; bits 4:3 are held at zero
	logic [7:0]               ctrl_r;
	// last legal rate code asked for; reserved codes never reach the core
	logic [1:0]               rate_req_r;

	// address phase captured for the data phase that follows
	logic                     wr_pend_r;
	logic [9:0]               addr_r;

	// registered bus answer; this slave never stretches a transfer
	logic [31:0]              hrdata_r;
	logic                     hreadyout_r;
	logic                     hresp_r;

	// settings the core really uses, held in the sequencer
	logic                     running_r;
	logic [1:0]               rate_r;
	logic                     bank_b_r;
	logic                     clear_r;

	// settings software asks for, taken from the control register
	core_ctrl_pkg::core_cfg_s req;

	// address compare, shared by the write strobe and the read selects
	// one place to change if the map ever grows a second writable word
	function automatic logic addr_is(
		input logic [9:0] a,
		input logic [9:0] base
	);
		return (a == base);
	endfunction

	// bank decode: the reserved codes fall back to bank A
	// so a stray code never leaves the core without a bank
	function automatic logic bank_is_b(
		input logic [1:0] code
	);
		return (code == core_ctrl_pkg::BANK_B);
	endfunction

	// rate decode: only the two defined rates are legal
	// a reserved rate would leave the core with no valid sample clock
	function automatic logic rate_legal(
		input logic [1:0] code
	);
		return (code == core_ctrl_pkg::RATE_96K)
			|| (code == core_ctrl_pkg::RATE_192K);
	endfunction

	// address phase qualifiers; a transfer is taken only when all agree
	// hready low means another transfer still owns the bus
	wire sel_ok    = hsel && hready;
	wire nonseq_ok = (htrans == core_ctrl_pkg::HTRANS_NONSEQ);
	// other sizes are answered okay but dropped, so a byte write cannot half-set a field
	wire size_ok   = (hsize == core_ctrl_pkg::HSIZE_WORD);
	wire take      = sel_ok && nonseq_ok && size_ok;
	// direction split of the taken transfer
	wire wr_take   = take && hwrite;
	wire rd_take   = take && !hwrite;

	// data phase write strobe for the control register
	wire wr_ctrl   = wr_pend_r && addr_is(addr_r, core_ctrl_pkg::CTRL_BYTE_ADDR);

	// address phase read selects
	wire rd_ctrl   = addr_is(haddr, core_ctrl_pkg::CTRL_BYTE_ADDR);
	wire rd_status = addr_is(haddr, core_ctrl_pkg::STATUS_BYTE_ADDR);

	// unused bits masked
	// masking on the way in keeps bits 4:3 zero for every later read
	wire [7:0] wr_byte  = hwdata[7:0];
	wire [7:0] ctrl_nxt = wr_byte & core_ctrl_pkg::CTRL_WMASK;

	// reserved rates dropped
	// a write with a reserved rate keeps the last legal request
	wire [1:0] wr_rate   = ctrl_nxt[core_ctrl_pkg::RATE_MSB:core_ctrl_pkg::RATE_LSB];
	// the rest of the byte still lands; only the rate request is held back
	wire       rate_take = wr_ctrl && rate_legal(wr_rate);

	// a read right behind a write to the same register sees the new byte
	// without this a back-to-back read would return the stale value
	wire [7:0] ctrl_view = wr_ctrl ? ctrl_nxt : ctrl_r;

	// fields steer the sequencer
	// run and bank only take hold at the next program start
	// run request
	assign req.run      = ctrl_r[core_ctrl_pkg::RUN_BIT];
	assign req.rate     = rate_req_r;
	assign req.bank_b   = bank_is_b(ctrl_r[core_ctrl_pkg::BANK_MSB:core_ctrl_pkg::BANK_LSB]);
	assign req.clr_hist = ctrl_r[core_ctrl_pkg::CLR_HIST_BIT];

	// read words; status shows what the core runs with, which may lag the control byte
	wire [31:0] ctrl_word   = {24'h000000, ctrl_view};
	wire [31:0] status_word = {27'h0000000, clear_r, bank_b_r, rate_r, running_r};

	// read mux; unmapped addresses read zero with an okay answer
	// so software probing the map never sees an error
	wire [31:0] rd_val =
		rd_ctrl   ? ctrl_word :
		rd_status ? status_word :
		32'h00000000;

	// address phase capture; held while another slave stretches the bus
	// a write only counts once its address phase has really been accepted
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_pend_r <= 1'b0;
			addr_r    <= '0;
		end else if (hready) begin
			wr_pend_r <= wr_take;
			addr_r    <= haddr;
		end
	end

	// control register; the write lands at the end of the data phase
	// hwdata is only valid in the data phase, never in the address phase
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_r <= core_ctrl_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// legal rate request
	// kept apart from the control byte so the readback shows what was written
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rate_req_r <= core_ctrl_pkg::CTRL_RESET[core_ctrl_pkg::RATE_MSB:core_ctrl_pkg::RATE_LSB];
		end else if (rate_take) begin
			rate_req_r <= wr_rate;
		end
	end

	// read data is launched at the address phase edge
	// it stands through the data phase and until the next read
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hrdata_r <= '0;
		end else if (rd_take) begin
			hrdata_r <= rd_val;
		end
	end

	// zero-wait slave: always ready, always okay
	// flopped so that every output leaves a register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
	end

	// boundary sequencing
	// the sequencer keeps run, bank and wipe on program boundaries
	core_sequencer #(
		.CLEAR_CYCLES(CLEAR_CYCLES)
	) u_seq (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.req       (req),
		.prog_start(prog_start),
		.running_r (running_r),
		.rate_r    (rate_r),
		.bank_b_r  (bank_b_r),
		.clear_r   (clear_r)
	);

	// bus answer straight from its flops
	assign hrdata       = hrdata_r;
	assign hreadyout    = hreadyout_r;
	assign hresp        = hresp_r;

	// core settings straight from the sequencer flops
	assign core_running = running_r;
	assign core_rate    = rate_r;
	assign core_bank_b  = bank_b_r;
	assign core_clear   = clear_r;
endmodule // core_run_bank_control

/* core_ctrl_asserts.sv */
`timescale 1ns/10ps
// watches the core-side ports; the burst length assumes the default count of 4
module core_ctrl_asserts #(
	parameter int CLEAR_CYCLES = 4
) (
	input wire logic       clk_sys,
	input wire logic       srst,
	input wire logic       prog_start,
	input wire logic       core_running,
	input wire logic [1:0] core_rate,
	input wire logic       core_bank_b,
	input wire logic       core_clear
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// a history wipe lasts exactly four cycles, then drops
	sequence s_burst;
		core_clear [*4] ##1 !core_clear;
	endsequence
	chk_run_at_start: assert property ($changed(core_running) |-> $past(prog_start))
		else $error("run changed away from program start");
	chk_bank_at_start: assert property ($changed(core_bank_b) |-> $past(prog_start))
		else $error("bank changed away from program start");
	chk_rate_when_stopped: assert property ($changed(core_rate) |-> !$past(core_running))
		else $error("rate changed while running");
	chk_rate_code: assert property ($changed(core_rate) |-> core_rate inside {2'h1, 2'h2})
		else $error("rate took a reserved code");
	chk_clear_burst: assert property ($rose(core_clear) |-> s_burst)
		else $error("wipe length wrong");
	chk_clear_cause: assert property ($rose(core_clear) |-> $past(prog_start) || $past(prog_start, 2))
		else $error("wipe without program start");
endmodule // core_ctrl_asserts

bind core_run_bank_control core_ctrl_asserts #(.CLEAR_CYCLES(CLEAR_CYCLES)) i_chk (.clk_sys, .srst, .prog_start,
	.core_running, .core_rate, .core_bank_b, .core_clear);

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
	logic        clk_sys = 0, srst = 1, hsel = 0, hwrite = 0, prog_start = 0;
	logic [9:0]  haddr = '0;
	logic [1:0]  htrans = '0;
	logic [31:0] hwdata = '0;
	wire logic [31:0] hrdata;
	wire logic [1:0]  core_rate;
	wire logic        hreadyout, hresp, core_running, core_bank_b, core_clear;
	int fails = 0, num_checks = 0;
	localparam logic [9:0] CA = core_ctrl_pkg::CTRL_BYTE_ADDR;
	// hready is fed back from the only slave
	core_run_bank_control i_dut (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(core_ctrl_pkg::HSIZE_WORD),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .prog_start, .core_running, .core_rate,
		.core_bank_b, .core_clear);
	always #12.5 clk_sys = ~clk_sys;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one single word transfer; read data taken at the closing edge
	task automatic xfer(input logic [9:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= core_ctrl_pkg::HTRANS_NONSEQ;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
		chk(32'(hresp), 32'h0);
	endtask
	task automatic pulse;
		prog_start <= 1'b1;
		@(posedge clk_sys);
		prog_start <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic t_fields;
		logic [31:0] q;
		xfer(CA, 0, 0, q);
		chk(q, 32'h04);
		chk(32'(core_rate), 32'h2);
		xfer(CA, 1, 32'hFFFF_FF7E, q);
		xfer(CA, 0, 0, q);
		chk(q, 32'h66);
		repeat (2) @(posedge clk_sys);
		chk(32'(core_rate), 32'h2);
		xfer(10'h3FC, 1, 32'h1, q);
		xfer(10'h3FC, 0, 0, q);
		chk(q, 32'h0);
	endtask
	task automatic t_rate;
		logic [31:0] q;
		xfer(CA, 1, 32'h02, q);
		repeat (2) @(posedge clk_sys);
		chk(32'(core_rate), 32'h1);
		xfer(CA, 1, 32'h03, q);
		pulse();
		chk(32'(core_running), 32'h1);
		xfer(CA, 1, 32'h05, q);
		xfer(CA, 1, 32'h04, q);
		repeat (2) @(posedge clk_sys);
		chk({core_running, core_rate}, 32'h5);
		pulse();
		repeat (2) @(posedge clk_sys);
		chk({core_running, core_rate}, 32'h2);
		xfer(core_ctrl_pkg::STATUS_BYTE_ADDR, 0, 0, q);
		chk(q, 32'h04);
	endtask
	// wipe must follow a switch only when bit 7 asks for it
	task automatic t_bank;
		logic [31:0] q;
		int n;
		for (int i = 0; i < 2; i++) begin
			xfer(CA, 1, i ? 32'h85 : 32'h25, q);
			chk(32'(core_bank_b), 32'(i));
			pulse();
			n = 0;
			repeat (8) begin
				n += core_clear;
				@(posedge clk_sys);
			end
			chk({core_bank_b, 8'(n)}, i ? 32'h4 : 32'h100);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#100us;
		fails++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		t_fields();
		t_rate();
		t_bank();
		conclude();
	end
endmodule // testbench
